// file: core/pldm_meter.sv
// Purpose: measure how long a selected pin stays at a requested level
// Assumes: pin inputs synchronous to clk_i; one request at a time
// Notes: result in ticks of 8 reference cycles; seconds scale is done by software
`timescale 1ns/1ps

// How it works
// - time pin at requested low or high level
// - release pin to high impedance before sensing
// - pin stays high impedance after completion
// - count ticks of eight reference cycles
// - valid result 1 to 32767, signed 16-bit
// - no transition in range reports zero timeout
// - pin already away returns one at once
// - busy holds off clock, tasks and network
// - seconds variant timeout is exactly zero
// - seconds variant immediate exit is one tick
module pldm_meter
    import pldm_pkg::*;
#(
    // number of pins the meter can select among
    parameter int unsigned NUM_PINS = 32,
    // system clock rate that the tick divider runs from
    parameter int unsigned CLK_FREQ = CLK_HZ,
    // tick rate, eight reference cycles per tick
    parameter int unsigned TICK_FREQ = TICK_RATE_HZ
) (
    // clock and asynchronous active-low reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // one-cycle request strobe and the pin and level it asks for
    input wire logic start_i,
    input wire pldm_pkg::pldm_req_t req_i,
    // sensed pin levels, taken as synchronous to clk_i
    input wire logic [NUM_PINS-1:0] pin_in_i,
    // pin configuration wanted by the rest of the system
    input wire logic [NUM_PINS-1:0] pin_out_i,
    input wire logic [NUM_PINS-1:0] pin_oe_i,
    // pin configuration after the measured pins are released
    output logic [NUM_PINS-1:0] pin_out_o,
    output logic [NUM_PINS-1:0] pin_oe_o,
    // measurement running, and the matching system hold request
    output logic busy_o,
    output logic hold_system_o,
    // one-cycle completion pulse and the result it qualifies
    output logic done_o,
    output pldm_pkg::pldm_rsp_t rsp_o
);
    import pldm_pkg::*;

    // refuse pin counts that the select field cannot address;
    // the tick divider refuses rates it cannot serve on its own
    if (NUM_PINS < 1 || NUM_PINS > (1 << PIN_SEL_W)) begin
        $error("pldm_meter: NUM_PINS out of range");
    end

    // all state of the meter
    typedef struct packed {
        // sequencer state
        pldm_state_t state;
        // pin number taken with the request
        logic [PIN_SEL_W-1:0] pin;
        // level whose duration is being timed
        logic level;
        // ticks counted so far in this measurement
        logic [RESULT_W-1:0] count;
        // pins held undriven by a measurement
        logic [NUM_PINS-1:0] released;
        // drive requests last seen while idle, to spot a rewrite
        logic [NUM_PINS-1:0] oe_seen;
        // result of the latest measurement
        pldm_rsp_t rsp;
        // completion pulse
        logic done;
    } pldm_st_t;

    // registered state and its next value
    pldm_st_t st;
    pldm_st_t next_st;
    // one pulse per measurement tick
    logic tick;
    // holds the tick phase at zero outside a measurement
    logic tick_clear;
    // present level of the selected pin
    logic pin_level;
    // drive requests that software has just raised
    logic [NUM_PINS-1:0] oe_rise;

    // selects the sensed pin level
    function automatic logic pick_pin(input logic [NUM_PINS-1:0] pins,
                                      input logic [PIN_SEL_W-1:0] sel);
        pick_pin = pins[sel];
    endfunction

    // one-hot mask of a pin
    function automatic logic [NUM_PINS-1:0] pin_mask(input logic [PIN_SEL_W-1:0] sel);
        pin_mask = '0;
        pin_mask[sel] = 1'b1;
    endfunction

    // tick source restarts each measurement, so the first tick
    // comes a full tick period after sensing begins
    pldm_tick_gen #(
        .CLK_FREQ(CLK_FREQ),
        .TICK_FREQ(TICK_FREQ)
    ) u_tick (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .clear_i(tick_clear),
        .tick_o(tick)
    );

    // the sequencer only ever looks at the pin it was asked about
    assign pin_level = pick_pin(pin_in_i, st.pin);
    // the divider runs only while measuring
    assign tick_clear = (st.state != PLDM_MEASURE);
    // a drive request raised since the last idle cycle is a rewrite
    assign oe_rise = pin_oe_i & ~st.oe_seen;

    // sequencer: idle, release pin, measure, report
    always_comb begin
        // hold the present state unless a branch moves it
        next_st = st;
        // done is a pulse, low unless a branch raises it
        next_st.done = 1'b0;
        unique case (st.state)
            PLDM_IDLE: begin
                // take a request; the pin is released at this same edge
                if (start_i) begin
                    next_st.pin = req_i.pin;
                    next_st.level = req_i.level;
                    // every measurement counts from zero
                    next_st.count = COUNT_ZERO;
                    // give the pin one cycle undriven before its level is trusted
                    next_st.state = PLDM_SETTLE;
                end
            end
            PLDM_SETTLE: begin
                // pin now tri-stated; check starting level
                // already away: report the shortest valid result
                if (pin_level != st.level) begin
                    next_st.rsp.ticks = RESULT_ONE_TICK;
                    next_st.rsp.timeout = 1'b0;
                    next_st.rsp.immediate = 1'b1;
                    next_st.done = 1'b1;
                    next_st.state = PLDM_DONE;
                end else begin
                    // still at the level: start timing
                    next_st.state = PLDM_MEASURE;
                end
            end
            PLDM_MEASURE: begin
                if (pin_level != st.level) begin
                    // transition: report at least one tick
                    next_st.rsp.ticks = (st.count == COUNT_ZERO) ? RESULT_ONE_TICK
                                                                 : st.count;
                    next_st.rsp.timeout = 1'b0;
                    next_st.rsp.immediate = 1'b0;
                    next_st.done = 1'b1;
                    next_st.state = PLDM_DONE;
                end else if (tick) begin
                    // the level held for one more tick
                    if (st.count == MAX_TICKS) begin
                        // range exhausted, no wrap
                        next_st.rsp.ticks = RESULT_TIMEOUT;
                        next_st.rsp.timeout = 1'b1;
                        next_st.rsp.immediate = 1'b0;
                        next_st.done = 1'b1;
                        next_st.state = PLDM_DONE;
                    end else begin
                        // still inside the measurable range
                        next_st.count = st.count + 16'h0001;
                    end
                end
            end
            PLDM_DONE: begin
                // one cycle of rest before the next request
                next_st.state = PLDM_IDLE;
            end
        endcase
        // the release only ends at reset or when software raises a drive request again
        // while idle; a drive request that merely stays high from before the
        // measurement does not undo it, so the pin is left undriven
        if (st.state == PLDM_IDLE) begin
            // remember what software asked for, to see the next rise
            next_st.oe_seen = pin_oe_i;
            // a fresh drive request hands the pin back to the system
            next_st.released = st.released & ~oe_rise;
            // the requested pin is released at the edge that takes the request
            if (start_i) begin
                next_st.released = next_st.released | pin_mask(req_i.pin);
            end
        end
        // a rise while busy is not lost: oe_seen only moves while idle
    end

    // register the meter state
    always_ff @(posedge clk_i or negedge rstn_i) begin
        // reset frees every pin and drops any result
        if (!rstn_i) begin
            st.state <= PLDM_IDLE;
            st.pin <= '0;
            st.level <= 1'b0;
            st.count <= COUNT_ZERO;
            st.released <= '0;
            st.oe_seen <= '0;
            st.rsp <= '0;
            st.done <= 1'b0;
        // otherwise take the next state
        end else begin
            st <= next_st;
        end
    end

    // released pins are undriven, during and after measurement
    assign pin_oe_o = pin_oe_i & ~st.released;
    // a released pin also shows a quiet output value
    assign pin_out_o = pin_out_i & ~st.released;
    // busy from the take edge until back in idle
    assign busy_o = (st.state != PLDM_IDLE);
    // the rest of the system stands still while busy
    assign hold_system_o = busy_o;
    // result and its pulse come straight from the state register
    assign done_o = st.done;
    assign rsp_o = st.rsp;
endmodule

// file: core/pldm_pkg.sv
// Purpose: shared constants and types for the pin level duration meter
// Assumes: 50 MHz system clock, tick reference 7.3728 MHz divided by 8
// Notes: tick period is approximated by a fractional accumulator
package pldm_pkg;
    // clock and tick reference
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned REF_HZ = 7372800;
    localparam int unsigned REF_CYCLES_PER_TICK = 8;
    // fractional accumulator step: tick rate is REF_HZ / 8 per CLK_HZ
    localparam int unsigned TICK_RATE_HZ = REF_HZ / REF_CYCLES_PER_TICK;
    localparam int unsigned ACC_W = 27;
    // widths
    localparam int unsigned PIN_SEL_W = 5;
    localparam int unsigned RESULT_W = 16;
    // result values
    localparam logic [15:0] MAX_TICKS = 16'h7fff;
    localparam logic [15:0] RESULT_TIMEOUT = 16'h0000;
    localparam logic [15:0] RESULT_ONE_TICK = 16'h0001;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // request carried from the caller
    typedef struct packed {
        logic [PIN_SEL_W-1:0] pin;
        logic level;
    } pldm_req_t;

    // answer returned to the caller
    typedef struct packed {
        logic signed [RESULT_W-1:0] ticks;
        logic timeout;
        logic immediate;
    } pldm_rsp_t;

    // measurement sequencer states
    typedef enum logic [1:0] {
        PLDM_IDLE = 2'b00,
        PLDM_SETTLE = 2'b01,
        PLDM_MEASURE = 2'b10,
        PLDM_DONE = 2'b11
    } pldm_state_t;
endpackage

// file: core/pldm_tick_gen.sv
// Purpose: fractional divider producing one pulse per measurement tick
// Assumes: clear restarts the phase so a tick is a full period
// Notes: average tick rate is exact, jitter is one clock
`timescale 1ns/1ps
module pldm_tick_gen
    import pldm_pkg::*;
#(
    parameter int unsigned CLK_FREQ = CLK_HZ,
    parameter int unsigned TICK_FREQ = TICK_RATE_HZ
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic clear_i,
    output logic tick_o
);
    import pldm_pkg::*;

    // refuse rates that the accumulator cannot serve
    if (TICK_FREQ == 0 || TICK_FREQ >= CLK_FREQ || CLK_FREQ >= (1 << (ACC_W - 1))) begin
        $error("pldm_tick_gen: unsupported frequencies");
    end

    // all state of the divider
    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic tick;
    } pldm_tick_st_t;

    pldm_tick_st_t st;
    pldm_tick_st_t next_st;

    // accumulate tick rate, wrap at clock rate, pulse on wrap
    always_comb begin
        logic [ACC_W-1:0] sum;
        sum = st.acc + ACC_W'(TICK_FREQ);
        next_st = st;
        next_st.tick = 1'b0;
        if (clear_i) begin
            next_st.acc = '0;
        end else if (sum >= ACC_W'(CLK_FREQ)) begin
            next_st.acc = sum - ACC_W'(CLK_FREQ);
            next_st.tick = 1'b1;
        end else begin
            next_st.acc = sum;
        end
    end

    // register the divider state
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;
endmodule

// file: testbench/pldm_meter_monitor.sv
// Purpose: port checks for the meter
// Assumes: one request at a time
// Notes: pin_q and lvl_q hold the taken request
`timescale 1ns/1ps
module pldm_meter_monitor
    import pldm_pkg::*;
#(parameter int unsigned NUM_PINS = 32) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire pldm_pkg::pldm_req_t req_i,
    input wire logic [NUM_PINS-1:0] pin_in_i,
    input wire logic [NUM_PINS-1:0] pin_oe_o,
    input wire logic busy_o,
    input wire logic hold_system_o,
    input wire logic done_o,
    input wire pldm_pkg::pldm_rsp_t rsp_o
);
    logic [PIN_SEL_W-1:0] pin_q; // taken pin
    logic lvl_q; // taken level
    // latch the request on the edge that takes it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_q <= '0;
            lvl_q <= 1'b0;
        end else if (start_i && !busy_o) begin
            pin_q <= req_i.pin;
            lvl_q <= req_i.level;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_hold_busy: assert property (hold_system_o == busy_o)
        else $error("hold differs from busy");
    a_take_busy: assert property (start_i && !busy_o |=> busy_o)
        else $error("start not taken");
    a_pin_released: assert property (busy_o |-> !pin_oe_o[pin_q])
        else $error("pin driven while measuring");
    a_left_released: assert property (done_o |-> !pin_oe_o[pin_q])
        else $error("pin driven at completion");
    a_timeout_zero: assert property (done_o && rsp_o.timeout |-> rsp_o.ticks == 0)
        else $error("timeout result not zero");
    a_valid_range: assert property (done_o && !rsp_o.timeout |-> rsp_o.ticks > 0)
        else $error("result out of range");
    a_imm_one: assert property (done_o && rsp_o.immediate |-> rsp_o.ticks == 1)
        else $error("immediate result not one");
    a_imm_time: assert property ($rose(busy_o) && pin_in_i[pin_q] != lvl_q
        |=> done_o && rsp_o.immediate)
        else $error("immediate exit late");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_level_left: assert property (done_o && !rsp_o.immediate && !rsp_o.timeout
        |-> $past(pin_in_i[pin_q]) != lvl_q)
        else $error("done without a transition");
    c_imm: cover property (done_o && rsp_o.immediate);
    c_meas: cover property (done_o && !rsp_o.immediate);
    c_refused: cover property (start_i && busy_o);
    c_timeout: cover property (done_o && rsp_o.timeout);
endmodule
bind pldm_meter pldm_meter_monitor #(.NUM_PINS(NUM_PINS)) mon_u (.clk_i, .rstn_i, .start_i,
    .req_i, .pin_in_i, .pin_oe_o, .busy_o, .hold_system_o, .done_o, .rsp_o);

// file: testbench/pldm_rc_model.sv
// Purpose: rc node on one pin
// Assumes: node keeps the driven level charge_i cycles after release
// Notes: then it crosses to the other level
`timescale 1ns/1ps
module pldm_rc_model (
    input wire logic clk_i,
    input wire logic drive_i,
    input wire logic val_i,
    input wire logic [15:0] charge_i,
    output logic pin_o
);
    logic last = 1'b0; // level left by the driver
    logic [15:0] age = 16'h0000; // cycles since release
    // count from release, restart while driven
    always_ff @(posedge clk_i) begin
        if (drive_i) begin
            last <= val_i;
            age <= 16'h0000;
        end else if (age != 16'hffff) begin
            age <= age + 16'h0001;
        end
    end
    assign pin_o = drive_i ? val_i : (age < charge_i ? last : !last);
endmodule

// file: testbench/test_pldm_meter.sv
// Purpose: self-checking bench for the meter
// Assumes: 50 MHz clock, inputs move 1 ns after the edge
// Notes: row fields are pin, level, charge, immediate, second start
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module test_pldm_meter;
    import pldm_pkg::*;
    typedef struct packed {
        logic [4:0] pin;
        logic lv;
        logic [15:0] ch;
        logic im;
        logic poke;
    } pldm_row_t;
    logic clk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0, busy_o, hold_system_o, done_o, rc_pin;
    pldm_req_t req_i = '0;
    pldm_rsp_t rsp_o;
    logic [31:0] pin_in_i, pin_out_i = '0, pin_oe_i = '0, pin_out_o, pin_oe_o;
    logic [4:0] sel = '0;
    logic [15:0] charge = '0;
    int fail_count = 0, comparisons = 0;
    // second meter with a fast tick, so that the full range runs out quickly
    logic fast_start = 1'b0, fast_busy, fast_done;
    pldm_req_t fast_req = '{pin: 5'd2, level: 1'b0};
    pldm_rsp_t fast_rsp;
    logic [31:0] fast_pins = '0;
    pldm_row_t rows [5] = '{'{5'd3, 1'b0, 16'd600, 1'b0, 1'b1}, '{5'd17, 1'b1, 16'd2000, 1'b0,
        1'b0}, '{5'd0, 1'b0, 16'd2, 1'b0, 1'b0}, '{5'd31, 1'b1, 16'd400, 1'b1, 1'b0},
        '{5'd8, 1'b0, 16'd400, 1'b1, 1'b1}};
    pldm_meter #(.NUM_PINS(32)) dut_u (.clk_i, .rstn_i, .start_i, .req_i, .pin_in_i,
        .pin_out_i, .pin_oe_i, .pin_out_o, .pin_oe_o, .busy_o, .hold_system_o, .done_o, .rsp_o);
    pldm_rc_model rc_u (.clk_i, .drive_i(pin_oe_o[sel]), .val_i(pin_out_o[sel]),
        .charge_i(charge), .pin_o(rc_pin));
    // its pins all sit low, so a low-level request can only time out
    pldm_meter #(.NUM_PINS(32), .TICK_FREQ(CLK_HZ / 2)) fast_u (.clk_i, .rstn_i,
        .start_i(fast_start), .req_i(fast_req), .pin_in_i(fast_pins), .pin_out_i(fast_pins),
        .pin_oe_i(fast_pins), .pin_out_o(), .pin_oe_o(), .busy_o(fast_busy),
        .hold_system_o(), .done_o(fast_done), .rsp_o(fast_rsp));
    // selected pin comes from the node, the rest from the drivers
    always_comb begin
        pin_in_i = pin_out_o;
        pin_in_i[sel] = rc_pin;
    end
    initial begin
        forever #10 clk_i = !clk_i;
    end
    task automatic end_of_test;
        $display("compared %0d, bad %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // charge the node, start, optionally start again while busy
    task automatic launch(input pldm_row_t r);
        sel = r.pin;
        charge = r.ch;
        pin_out_i[r.pin] = r.im ? !r.lv : r.lv;
        pin_oe_i[r.pin] = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        req_i = '{pin: r.pin, level: r.lv};
        // the drive request stays up: the meter must override it
        start_i = 1'b1;
        @(posedge clk_i);
        #1;
        start_i = r.poke;
        req_i.level = !r.lv;
    endtask
    task automatic run(input pldm_row_t r);
        int n, e, lo, hi;
        launch(r);
        `CHK(pin_oe_o[r.pin], 1'b0)
        `CHK(hold_system_o, 1'b1)
        @(posedge clk_i);
        #1;
        start_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        `CHK(done_o, 1'b1)
        e = r.ch * 9216 / 500000;
        lo = r.im ? 1 : (e > 1 ? e - 1 : 1);
        hi = r.im ? 1 : e + 2;
        if (r.im) `CHK(n, 0)
        `CHK(rsp_o.immediate, r.im)
        `CHK(rsp_o.timeout, 1'b0)
        `CHK(rsp_o.ticks >= lo && rsp_o.ticks <= hi, 1'b1)
        @(posedge clk_i);
        #1;
        `CHK(busy_o, 1'b0)
        `CHK(pin_oe_o[r.pin], 1'b0)
        $display("test pin %0d done", r.pin);
    endtask
    initial begin
        int n, e;
        repeat (16) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        foreach (rows[i]) run(rows[i]);
        // a pin that never leaves its level runs the fast meter out of range
        fast_start = 1'b1;
        @(posedge clk_i);
        #1;
        fast_start = 1'b0;
        n = 0;
        while (fast_done !== 1'b1 && n < 70000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        // 32768 ticks of two clocks each; the settle cycle is left to the slack of four
        e = 2 * (int'(MAX_TICKS) + 1);
        `CHK(fast_done, 1'b1)
        `CHK(fast_rsp.timeout, 1'b1)
        `CHK(fast_rsp.ticks, 16'h0000)
        `CHK(fast_rsp.immediate, 1'b0)
        `CHK(n >= e - 4 && n <= e + 4, 1'b1)
        @(posedge clk_i);
        #1;
        `CHK(fast_busy, 1'b0)
        $display("test timeout done");
        // reset in mid measurement frees the pin and ends busy
        launch('{5'd9, 1'b0, 16'd3000, 1'b0, 1'b0});
        repeat (20) @(posedge clk_i);
        #1;
        rstn_i = 1'b0;
        start_i = 1'b0;
        #1;
        `CHK(hold_system_o, 1'b0)
        `CHK(pin_oe_o, pin_oe_i)
        $display("test reset done");
        end_of_test();
    end
    initial begin
        // the tests take about 70000 cycles of 20 ns; allow some margin
        #1800000;
        fail_count++;
        end_of_test();
    end
endmodule
